// file: core/psi_clkstop.sv
`timescale 1ns/1ps
`default_nettype none

module psi_clkstop (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link activity
  input wire logic i_active,
  input wire logic i_change,
  // status
  output logic o_stopped
);
  import psi_pkg::*;

  psi_tmr_t cnt_q;
  logic hit;

  assign hit = (cnt_q >= STOP_T - 16'h0001);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_active || i_change) begin
      cnt_q <= 16'h0000;
    end else if (!hit) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !i_active || i_change) begin
      o_stopped <= 1'b0;
    end else if (hit) begin
      o_stopped <= 1'b1;
    end
  end

  chk_stop_entry: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    (i_active && !i_change)[*8] ##1 (i_active && !i_change && hit)
    |=> o_stopped) else $error("clock stop not entered");
  chk_stop_resume: assert property (
    @(posedge i_clk_sys) disable iff (i_rst)
    i_change |=> !o_stopped) else $error("clock stop kept");
endmodule

`default_nettype wire

// file: core/psi_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module psi_ctrl #(
  parameter logic DUAL_DIE = 1'b0,
  parameter psi_pkg::psi_tmr_t WAKE_CYC_P = psi_pkg::WAKE_T,
  parameter psi_pkg::psi_tmr_t PWRUP_CYC_P = psi_pkg::PWRUP_T
) (
  // clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // link pins
  input wire logic i_sel_n,
  input wire logic i_ck,
  input wire logic i_clock_complement,
  input wire logic i_warm_rst_n,
  input wire logic [7:0] i_byte_lane,
  input wire logic i_strobe_mask_line,
  output psi_pkg::psi_pins_s o_pins,
  // memory core side
  input wire logic i_refresh_busy,
  input wire logic [7:0] i_rd_data,
  output logic o_rd_req,
  output logic [31:0] o_rd_addr,
  output logic o_wr_valid,
  output psi_pkg::psi_wr_s o_wr,
  // status
  output logic [15:0] o_config_zero,
  output logic o_refresh_en,
  output logic o_deep_sleep,
  output logic o_clock_stop,
  output logic o_standby
);
  import psi_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers and edge finding
  // ---------------------------------------------------------------
  logic [12:0] pin_s;
  logic sel_n_s, ck_s, comp_s, warm_n_s, smask_s;
  logic [7:0] byte_s;
  logic ck_q, comp_q;

  psi_sync #(.W(13)) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_async({i_sel_n, i_ck, i_clock_complement, i_warm_rst_n,
              i_strobe_mask_line, i_byte_lane}),
    .o_sync(pin_s)
  );

  assign {sel_n_s, ck_s, comp_s, warm_n_s, smask_s, byte_s} = pin_s;

  always_ff @(posedge i_clk_sys) begin
    ck_q <= ck_s;
    comp_q <= comp_s;
  end

  wire logic sel = !sel_n_s;
  wire logic warm = !warm_n_s;
  wire logic edge_ck = ck_s ^ ck_q;
  wire logic clk_change = edge_ck | (comp_s ^ comp_q);

  // ---------------------------------------------------------------
  // state and storage
  // ---------------------------------------------------------------
  psi_st_e st_q, st_d, ca_nxt;
  logic [4:0] cnt_q;
  logic [39:0] ca_q;
  logic ext_q, rd_q, reg_q, hi_q, rd_pend_q, pend_q;
  logic [7:0] hi_byte_q;
  logic [31:0] addr_q;
  logic [15:0] cfg_q;
  psi_tmr_t tmr_q, low_q;
  psi_pins_s pins_q, pins_d;
  psi_wr_s wr_q;
  logic wr_valid_q, rd_req_q;
  logic stby_q, sleep_q, refr_q;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [47:0] ca_full = {ca_q, byte_s};
  wire logic in_xfer = st_q inside {ST_CA, ST_RLAT, ST_WLAT,
                                    ST_RDAT, ST_WDAT, ST_ZWDAT};
  wire logic in_data = in_xfer && (st_q != ST_CA);
  wire logic [4:0] lat_len = ext_q ? LAT_EXT_EDGES : LAT_EDGES;
  wire logic ca_done = (st_q == ST_CA) && edge_ck &&
                       (cnt_q == CA_EDGES - 5'h01);
  wire logic lat_done = (st_q inside {ST_RLAT, ST_WLAT}) && edge_ck &&
                        (cnt_q == lat_len - 5'h01);
  wire logic tmr_zero = (tmr_q == 16'h0000);
  wire logic low_ok = (low_q >= WAKE_SEL_T);
  wire logic sleep_go = pend_q && tmr_zero;
  wire logic tmr_ld_wake = warm || ((st_q == ST_SLEEP) && (st_d == ST_WAKE));
  wire logic load = rd_pend_q && (st_q == ST_RDAT) && sel;
  wire logic zw_edge = (st_q == ST_ZWDAT) && edge_ck && sel;
  wire logic hi_step = (reg_q && load) || zw_edge;
  wire logic [15:0] cfg_new = {hi_byte_q, byte_s};
  wire logic cfg_wr = zw_edge && !hi_q && (addr_q == CFG0_ADDR);
  wire logic pend_set = cfg_wr && !cfg_new[CFG0_SLEEP_BIT] && !DUAL_DIE;
  wire logic ext_d = (st_q == ST_STBY) ? i_refresh_busy : ext_q;
  wire logic [7:0] cfg_byte = hi_q ? cfg_q[15:8] : cfg_q[7:0];
  wire logic [7:0] rd_byte = reg_q ? cfg_byte : i_rd_data;
  wire logic wr_fire = (st_q == ST_WDAT) && edge_ck && sel;
  wire logic rd_fire = (st_q == ST_RDAT) && edge_ck && sel;

  assign ca_nxt = ca_full[CA_RW_BIT] ? ST_RLAT :
                  ca_full[CA_SPACE_BIT] ? ST_ZWDAT : ST_WLAT;

  // ---------------------------------------------------------------
  // bus phase sequencing
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_PWRUP: if (tmr_zero) begin
        st_d = ST_STBY;
      end
      ST_STBY: if (sleep_go) begin
        st_d = ST_SLEEP;
      end else if (sel) begin
        st_d = ST_CA;
      end
      ST_CA: if (ca_done) begin
        st_d = ca_nxt;
      end
      ST_RLAT: if (lat_done) begin
        st_d = ST_RDAT;
      end
      ST_WLAT: if (lat_done) begin
        st_d = ST_WDAT;
      end
      ST_SLEEP: if (!sel && low_ok) begin
        st_d = ST_WAKE;
      end
      ST_WAKE: if (tmr_zero) begin
        st_d = ST_STBY;
      end
      ST_RDAT, ST_WDAT, ST_ZWDAT: st_d = st_q;
      default: st_d = ST_STBY;
    endcase
    if (in_xfer && !sel) begin
      st_d = ST_STBY;
    end
    if (warm) begin
      st_d = ST_WAKE;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= ST_PWRUP;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (st_d != st_q)) begin
      cnt_q <= 5'h00;
    end else if (edge_ck && (cnt_q != 5'h1f)) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // ---------------------------------------------------------------
  // command-address capture
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ca_q <= 40'h00_0000_0000;
    end else if ((st_q == ST_CA) && edge_ck) begin
      ca_q <= ca_full[39:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_q <= 1'b0;
      rd_q <= 1'b0;
      reg_q <= 1'b0;
    end else begin
      ext_q <= ext_d;
      if (ca_done) begin
        rd_q <= ca_full[CA_RW_BIT];
        reg_q <= ca_full[CA_SPACE_BIT];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr_q <= 32'h0000_0000;
    end else if (ca_done) begin
      addr_q <= {ca_full[44:16], ca_full[2:0]};
    end else if (wr_fire || rd_req_q) begin
      addr_q <= addr_q + 32'h0000_0001;
    end
  end

  // ---------------------------------------------------------------
  // configuration register zero and deep sleep timing
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hi_q <= 1'b1;
      hi_byte_q <= 8'h00;
    end else begin
      if (ca_done) begin
        hi_q <= 1'b1;
      end else if (hi_step) begin
        hi_q <= !hi_q;
      end
      if (zw_edge && hi_q) begin
        hi_byte_q <= byte_s;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (st_d == ST_WAKE)) begin
      cfg_q <= CFG0_RST;
    end else if (cfg_wr) begin
      cfg_q <= cfg_new;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || tmr_ld_wake || (st_d == ST_SLEEP)) begin
      pend_q <= 1'b0;
    end else if (pend_set) begin
      pend_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tmr_q <= PWRUP_CYC_P;
    end else if (tmr_ld_wake) begin
      tmr_q <= WAKE_CYC_P;
    end else if (pend_set) begin
      tmr_q <= SLEEP_IN_T;
    end else if (!tmr_zero) begin
      tmr_q <= tmr_q - 16'h0001;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || (st_q != ST_SLEEP) || !sel) begin
      low_q <= 16'h0000;
    end else if (!low_ok) begin
      low_q <= low_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb begin
    pins_d = pins_q;
    pins_d.byte_lane_oe = 1'b0;
    pins_d.strobe_mask_oe = 1'b0;
    pins_d.strobe_mask_line = 1'b0;
    case (st_d)
      ST_CA: begin
        pins_d.strobe_mask_oe = 1'b1;
        pins_d.strobe_mask_line = ext_d;
      end
      ST_RLAT: pins_d.strobe_mask_oe = 1'b1;
      ST_RDAT: begin
        pins_d.byte_lane_oe = pins_q.byte_lane_oe || load;
        pins_d.strobe_mask_oe = 1'b1;
        pins_d.strobe_mask_line = load ? !pins_q.strobe_mask_line :
                                         pins_q.strobe_mask_line;
        if (load) begin
          pins_d.byte_lane = rd_byte;
        end
      end
      default: pins_d.strobe_mask_oe = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  // ---------------------------------------------------------------
  // memory core requests
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rd_pend_q <= 1'b0;
      rd_req_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_q <= '0;
    end else begin
      rd_pend_q <= rd_fire;
      rd_req_q <= rd_fire && !reg_q;
      wr_valid_q <= wr_fire;
      if (wr_fire) begin
        wr_q <= '{addr: addr_q, data: byte_s, mask: smask_s};
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      stby_q <= 1'b0;
      sleep_q <= 1'b0;
      refr_q <= 1'b1;
    end else begin
      stby_q <= (st_d == ST_STBY);
      sleep_q <= (st_d == ST_SLEEP);
      refr_q <= (st_d != ST_SLEEP);
    end
  end

  psi_clkstop u_clkstop (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_active(in_data && sel),
    .i_change(clk_change),
    .o_stopped(o_clock_stop)
  );

  assign o_pins = pins_q;
  assign o_rd_req = rd_req_q;
  assign o_rd_addr = addr_q;
  assign o_wr_valid = wr_valid_q;
  assign o_wr = wr_q;
  assign o_config_zero = cfg_q;
  assign o_refresh_en = refr_q;
  assign o_deep_sleep = sleep_q;
  assign o_standby = stby_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_wake_pulse;
    (st_q == ST_SLEEP) && !warm && !sel && low_ok;
  endsequence

  sequence s_busy_start;
    (st_q == ST_STBY) && (st_d == ST_CA) && i_refresh_busy;
  endsequence

  chk_ca_strobe_drive: assert property (
    (st_q == ST_CA) |-> pins_q.strobe_mask_oe &&
      (pins_q.strobe_mask_line == ext_q))
    else $error("strobe not driven in address phase");
  chk_busy_latency: assert property (
    s_busy_start |=> pins_q.strobe_mask_line && (lat_len == LAT_EXT_EDGES))
    else $error("refresh busy not signalled");
  chk_read_turn: assert property (
    (st_q == ST_RLAT) |-> rd_q && !pins_q.byte_lane_oe &&
      pins_q.strobe_mask_oe && !pins_q.strobe_mask_line)
    else $error("read latency bus wrong");
  chk_write_turn: assert property (
    (st_q inside {ST_WLAT, ST_WDAT}) |-> !rd_q && !pins_q.byte_lane_oe &&
      !pins_q.strobe_mask_oe)
    else $error("write latency bus wrong");
  chk_zero_release: assert property (
    (ca_done && (ca_nxt == ST_ZWDAT) && sel && !warm)
      |=> (st_q == ST_ZWDAT) && !pins_q.strobe_mask_oe)
    else $error("strobe kept in zero-latency write");
  chk_standby_quiet: assert property (
    (st_q == ST_STBY) |-> !pins_q.byte_lane_oe &&
      !pins_q.strobe_mask_oe && o_standby)
    else $error("standby drives pins");
  chk_warm_float: assert property (
    warm |=> !pins_q.byte_lane_oe && !pins_q.strobe_mask_oe &&
      (st_q == ST_WAKE))
    else $error("pins driven in reset");
  chk_sleep_entry: assert property (
    $rose(pend_q) |-> (tmr_q == SLEEP_IN_T) ##1 (st_q != ST_SLEEP))
    else $error("deep sleep entered early");
  chk_sleep_refresh: assert property (
    (st_q == ST_SLEEP) |-> !o_refresh_en && o_deep_sleep)
    else $error("refresh runs in deep sleep");
  chk_dummy_exit: assert property (
    s_wake_pulse |=> (st_q == ST_WAKE) && (tmr_q == WAKE_CYC_P))
    else $error("dummy pulse did not wake");
  chk_wake_default: assert property (
    (st_q == ST_WAKE) |-> (cfg_q == CFG0_RST) && !pend_q)
    else $error("config not default after wake");
  chk_read_hold: assert property (
    (o_clock_stop && (st_q == ST_RDAT) && pins_q.byte_lane_oe)
      |=> $stable(pins_q.byte_lane) && pins_q.byte_lane_oe)
    else $error("read data not held in clock stop");
endmodule

`default_nettype wire

// file: core/psi_pkg.sv
package psi_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 25;
  localparam int SLEEP_IN_US = 10;
  localparam int SLEEP_IN_CYC = (SLEEP_IN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_SEL_NS = 200;
  localparam int WAKE_SEL_CYC = (WAKE_SEL_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_US = 150;
  localparam int WAKE_CYC = (WAKE_US * 1000) / CLK_NS;
  localparam int ACC_NS = 200;
  localparam int STOP_EXTRA_NS = 30;
  localparam int STOP_CYC = (ACC_NS + STOP_EXTRA_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWRUP_CYC = 1000;

  typedef logic [15:0] psi_tmr_t;
  localparam psi_tmr_t SLEEP_IN_T = psi_tmr_t'(SLEEP_IN_CYC);
  localparam psi_tmr_t WAKE_SEL_T = psi_tmr_t'(WAKE_SEL_CYC);
  localparam psi_tmr_t WAKE_T = psi_tmr_t'(WAKE_CYC);
  localparam psi_tmr_t STOP_T = psi_tmr_t'(STOP_CYC);
  localparam psi_tmr_t PWRUP_T = psi_tmr_t'(PWRUP_CYC);

  // ---------------------------------------------------------------
  // bus phases, counted in link clock edges
  // ---------------------------------------------------------------
  localparam int LAT_CLKS = 6;
  localparam logic [4:0] CA_EDGES = 5'h06;
  localparam logic [4:0] LAT_EDGES = 5'(2 * LAT_CLKS);
  localparam logic [4:0] LAT_EXT_EDGES = 5'(4 * LAT_CLKS);
  localparam int CA_RW_BIT = 47;
  localparam int CA_SPACE_BIT = 46;

  // ---------------------------------------------------------------
  // configuration register zero
  // ---------------------------------------------------------------
  localparam logic [31:0] CFG0_ADDR = 32'h0000_0800;
  localparam logic [15:0] CFG0_RST = 16'h8f1f;
  localparam int CFG0_SLEEP_BIT = 15;

  typedef enum logic [3:0] {
    ST_PWRUP, ST_STBY, ST_CA, ST_RLAT, ST_WLAT,
    ST_RDAT, ST_WDAT, ST_ZWDAT, ST_SLEEP, ST_WAKE
  } psi_st_e;

  typedef struct packed {
    logic [7:0] byte_lane;
    logic byte_lane_oe;
    logic strobe_mask_line;
    logic strobe_mask_oe;
  } psi_pins_s;

  typedef struct packed {
    logic [31:0] addr;
    logic [7:0] data;
    logic mask;
  } psi_wr_s;

endpackage

// file: core/psi_sync.sv
`timescale 1ns/1ps
`default_nettype none

module psi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk_sys,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      meta_q[g] <= i_async[g];
      o_sync[g] <= meta_q[g];
    end
  end
endmodule

`default_nettype wire

// file: sim/psi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psi_host_model (
  // system clock
  input wire logic i_clk_sys,
  // device side
  input wire psi_pkg::psi_pins_s i_pins,
  // link pins
  output logic o_sel_n,
  output logic o_ck,
  output logic o_ck_n,
  output logic [7:0] o_byte_lane,
  output logic o_strobe,
  // observations
  output logic o_ext,
  output logic [7:0] o_bad
);
  import psi_pkg::*;
  logic bl_drv;
  logic sm_drv;
  initial begin
    o_sel_n = 1'b1;
    o_ck = 1'b0;
    o_ck_n = 1'b1;
    o_byte_lane = 8'h00;
    o_strobe = 1'b0;
    o_ext = 1'b0;
    o_bad = 8'h00;
    bl_drv = 1'b0;
    sm_drv = 1'b0;
  end
  // --------------------
  // link edges
  // --------------------
  task automatic tick(input logic chk, input logic [2:0] exp);
    repeat (2) @(posedge i_clk_sys);
    #1;
    if (chk && {i_pins.byte_lane_oe, i_pins.strobe_mask_oe,
        i_pins.strobe_mask_oe & i_pins.strobe_mask_line} !== exp)
      o_bad = o_bad + 8'h01;
    o_ck = ~o_ck;
    o_ck_n = ~o_ck;
    // released lines do not keep their last level
    if (!bl_drv) o_byte_lane = ~o_byte_lane;
    if (!sm_drv) o_strobe = ~o_strobe;
    repeat (2) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic txn(input logic rd, input logic sp, input logic [31:0] a,
                     input int n, input logic [7:0] wd, input int stall);
    logic [47:0] ca;
    int lat;
    ca = {rd, sp, 1'b0, a[31:3], 13'h0000, a[2:0]};
    o_sel_n = 1'b0;
    bl_drv = 1'b1;
    repeat (5) @(posedge i_clk_sys);
    #1;
    o_ext = i_pins.strobe_mask_line;
    for (int i = 0; i < 6; i++) begin
      o_byte_lane = ca[47 - 8 * i -: 8];
      tick(1'b1, {2'b01, o_ext});
    end
    lat = o_ext ? int'(LAT_EXT_EDGES) : int'(LAT_EDGES);
    if (!rd && sp) lat = 0;
    bl_drv = 1'b0;
    for (int i = 0; i < lat; i++) begin
      tick(i > 1, rd ? 3'b010 : 3'b000);
    end
    for (int i = 0; i < n; i++) begin
      bl_drv = ~rd;
      sm_drv = ~rd & ~sp;
      if (!rd) o_byte_lane = wd + 8'(i);
      if (sm_drv) o_strobe = i[0];
      tick(~rd & sp & (i > 0), 3'b000);
      if (i == 1 && stall > 0) begin
        repeat (stall) @(posedge i_clk_sys);
        #1;
      end
    end
    bl_drv = 1'b0;
    sm_drv = 1'b0;
    repeat (6) @(posedge i_clk_sys);
    #1;
    o_sel_n = 1'b1;
    repeat (8) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic pulse(input int low);
    o_sel_n = 1'b0;
    repeat (low) @(posedge i_clk_sys);
    #1;
    o_sel_n = 1'b1;
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import psi_pkg::*;
  localparam psi_tmr_t WAKE_P = 16'h0028;
  localparam psi_tmr_t PWR_P = 16'h0014;
  typedef struct {
    logic rd;
    logic sp;
    logic bsy;
    logic [31:0] a;
    int n;
    logic sm;
  } psi_row_s;
  psi_row_s rows [5] = '{'{1'b1, 1'b0, 1'b0, 32'h10, 4, 1'b0},
    '{1'b1, 1'b0, 1'b1, 32'h23, 4, 1'b1},
    '{1'b0, 1'b0, 1'b0, 32'h40, 4, 1'b0},
    '{1'b0, 1'b0, 1'b1, 32'h7, 2, 1'b1},
    '{1'b1, 1'b1, 1'b0, 32'h800, 4, 1'b0}};
  logic clk, rst, warm_n, busy, sel_n, ck, ck_n, hsm, ext, sm_q;
  logic rd_req, wr_valid, ref_en, dsl, cstop, stby;
  logic [7:0] hbl, rd_data, bad, held;
  logic [31:0] rd_addr;
  logic [15:0] cfg;
  psi_pins_s pins;
  psi_wr_s wr;
  wire logic [7:0] bl_in;
  wire logic sm_in;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_rd = 0;
  int n_cs = 0;
  int k, base;
  logic [7:0] rq [$];
  psi_wr_s wq [$];
  assign bl_in = pins.byte_lane_oe ? pins.byte_lane : hbl;
  assign sm_in = pins.strobe_mask_oe ? pins.strobe_mask_line : hsm;
  psi_ctrl #(.DUAL_DIE(1'b0), .WAKE_CYC_P(WAKE_P), .PWRUP_CYC_P(PWR_P))
  i_psi_ctrl (.i_clk_sys(clk), .i_rst(rst), .i_sel_n(sel_n), .i_ck(ck),
    .i_clock_complement(ck_n), .i_warm_rst_n(warm_n), .i_byte_lane(bl_in),
    .i_strobe_mask_line(sm_in), .o_pins(pins), .i_refresh_busy(busy),
    .i_rd_data(rd_data), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
    .o_wr_valid(wr_valid), .o_wr(wr), .o_config_zero(cfg),
    .o_refresh_en(ref_en), .o_deep_sleep(dsl), .o_clock_stop(cstop),
    .o_standby(stby));
  psi_host_model i_psi_host_model (.i_clk_sys(clk), .i_pins(pins),
    .o_sel_n(sel_n), .o_ck(ck), .o_ck_n(ck_n), .o_byte_lane(hbl),
    .o_strobe(hsm), .o_ext(ext), .o_bad(bad));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // --------------------
  // memory core and monitors
  // --------------------
  // core answers in the cycle of its request
  assign rd_data = rd_addr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    if (rd_req === 1'b1) n_rd <= n_rd + 1;
    if (cstop === 1'b1) n_cs <= n_cs + 1;
    if (wr_valid === 1'b1) wq.push_back(wr);
    if (pins.byte_lane_oe === 1'b1 && pins.strobe_mask_line !== sm_q)
      rq.push_back(pins.byte_lane);
    sm_q <= pins.strobe_mask_line;
  end
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic probe(input int w);
    return (w == 0) ? stby : (w == 1) ? dsl : cstop;
  endfunction
  task automatic wait_for(input int w, input logic v, input int lim,
                          output int n);
    for (n = 0; n < lim && probe(w) !== v; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == lim) begin
      n_mismatch++;
      $display("MISMATCH wait %0d expected %b seen timeout", w, v);
      tally_and_finish();
    end
  endtask
  task automatic sleep_in();
    int m;
    i_psi_host_model.txn(1'b0, 1'b1, CFG0_ADDR, 2, 8'h0f, 0);
    check("cfg_wr", cfg, 16'h0f10);
    wait_for(1, 1'b1, 600, m);
    check("sleep_min", m >= SLEEP_IN_CYC - 16, 1'b1);
    check("refresh", ref_en, 1'b0);
  endtask
  // --------------------
  // main sequence
  // --------------------
  initial begin
    rst = 1'b1;
    warm_n = 1'b1;
    busy = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check("rst_pins", {pins.byte_lane_oe, pins.strobe_mask_oe, ref_en, stby},
          4'b0010);
    check("rst_cfg", cfg, CFG0_RST);
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    wait_for(0, 1'b1, PWR_P + 5, k);
    foreach (rows[r]) begin
      busy = rows[r].bsy;
      rq.delete();
      wq.delete();
      base = n_rd;
      i_psi_host_model.txn(rows[r].rd, rows[r].sp, rows[r].a, rows[r].n,
                           8'h30, 0);
      check("ca_strobe", ext, rows[r].sm);
      check("phase_pins", bad, 8'h00);
      check("standby", {stby, pins.byte_lane_oe, pins.strobe_mask_oe},
            3'b100);
      if (rows[r].rd) begin
        check("rd_cnt", rq.size(), rows[r].n);
        check("rd_req", n_rd - base, rows[r].sp ? 0 : rows[r].n);
        foreach (rq[j]) check("rd_byte", rq[j], rows[r].sp ?
          (j[0] ? CFG0_RST[7:0] : CFG0_RST[15:8]) :
          (rows[r].a[7:0] + 8'(j)) ^ 8'h5a);
      end else begin
        check("wr_cnt", wq.size(), rows[r].n);
        foreach (wq[j]) check("wr", wq[j], {rows[r].a + 32'(j),
          8'h30 + 8'(j), j[0]});
      end
    end
    busy = 1'b0;
    check("no_stop", n_cs, 0);
    rq.delete();
    fork
      i_psi_host_model.txn(1'b1, 1'b0, 32'h100, 4, 8'h00, 24);
      begin
        wait_for(2, 1'b1, 300, k);
        held = pins.byte_lane;
        repeat (4) @(posedge clk);
        #1;
        check("stop_hold", {pins.byte_lane_oe, pins.byte_lane},
              {1'b1, held});
      end
    join
    check("stop_len", n_cs inside {[14:22]}, 1'b1);
    check("stop_exit", {cstop, 8'(rq.size())}, 9'h004);
    check("stop_last", rq[3], 8'h03 ^ 8'h5a);
    sleep_in();
    base = n_rd;
    wq.delete();
    repeat (4) i_psi_host_model.tick(1'b0, 3'b000);
    i_psi_host_model.pulse(4);
    check("short_sel", {dsl, pins.byte_lane_oe, pins.strobe_mask_oe},
          3'b100);
    i_psi_host_model.pulse(12);
    wait_for(1, 1'b0, 20, k);
    wait_for(0, 1'b1, 200, k);
    check("wake_max", k <= WAKE_P + 4, 1'b1);
    check("wake_cfg", {cfg, ref_en}, {CFG0_RST, 1'b1});
    check("dummy", (n_rd - base) + wq.size(), 0);
    sleep_in();
    warm_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("warm_pins", {dsl, stby, pins.byte_lane_oe, pins.strobe_mask_oe},
          4'b0000);
    warm_n = 1'b1;
    wait_for(0, 1'b1, WAKE_P + 10, k);
    check("warm_cfg", {cfg, ref_en}, {CFG0_RST, 1'b1});
    check("phase_end", bad, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
